// file: src/tot_params.svh
`ifndef TOT_PARAMS_SVH
`define TOT_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define TOT_ADDR_W 8
`define TOT_OFS_CTRL 8'h00
`define TOT_OFS_PULSE 8'h04
`define TOT_OFS_WAIT 8'h08
`define TOT_OFS_FILT 8'h0C
`define TOT_OFS_CMD 8'h10
`define TOT_OFS_STAT 8'h14

// Field widths
`define TOT_DATA_W 32
`define TOT_CNT_W 26
`define TOT_FILT_W 20
`define TOT_CTRL_W 9

// Reset values
`define TOT_RST_CTRL 9'h000
`define TOT_RST_PULSE 26'h000_0001
`define TOT_RST_WAIT 26'h000_0000
`define TOT_RST_FILT 20'h0_0001

// Command and status bit positions
`define TOT_CMD_RESTART_BIT 0
`define TOT_STAT_STATE_LSB 0
`define TOT_STAT_ACTIVE_BIT 2
`define TOT_STAT_EXT_BIT 3
`define TOT_STAT_LINE_BIT 4

// AXI responses
`define TOT_RESP_OKAY 2'h0
`define TOT_RESP_SLVERR 2'h2

// Time base: 1 us tick from a 5 ns clock
`define TOT_CLK_PERIOD_PS 5000
`define TOT_TICK_US 1
`define TOT_TICK_CYC ((`TOT_TICK_US * 1000000) / `TOT_CLK_PERIOD_PS)
`define TOT_DIV_W 8

`endif

// file: src/tot_pkg.sv
package tot_pkg;

  typedef enum logic [1:0] {
    TOT_ORIG_OFF,
    TOT_ORIG_EXPOSURE,
    TOT_ORIG_READOUT,
    TOT_ORIG_EXTERNAL
  } tot_origin_e;

  typedef enum logic [1:0] {
    TOT_ON_LOW_TO_HIGH,
    TOT_ON_HIGH_TO_LOW,
    TOT_WHILE_ASSERTED_HIGH,
    TOT_WHILE_ASSERTED_LOW
  } tot_cond_e;

  typedef enum logic [2:0] {
    TOT_LINE_OFF,
    TOT_LINE_EXPOSURE,
    TOT_LINE_READOUT,
    TOT_LINE_USER,
    TOT_LINE_PULSE_GEN
  } tot_line_src_e;

  typedef enum logic [1:0] {
    TOT_IDLE,
    TOT_WAIT,
    TOT_PULSE
  } tot_state_e;

  typedef struct packed {
    logic user_value;
    logic output_polarity_flip;
    tot_line_src_e line_source;
    tot_cond_e trigger_condition_select;
    tot_origin_e trigger_origin_select;
  } tot_ctrl_s;

endpackage

// file: src/tot_trigger_timer.sv
// Summary of operation
// - Timer result reaches the output line only when line source selects it.
// - Trigger origin: off, exposure window, readout window or external input.
// - Edge modes hold the output active for the programmed pulse length in us.
// - After a valid trigger, wait the programmed delay before activating output.
// - Restart command clears pending wait or pulse; settings are kept.
// - Rising-edge mode: low-to-high transition starts the wait-then-pulse sequence.
// - Falling-edge mode: high-to-low transition starts the wait-then-pulse sequence.
// - High-level mode: output active while source stays high, pulse length ignored.
// - Low-level mode: output active while source stays low.
// - Level modes count wait from assertion; activate only if still asserted.
// - Per-line polarity flip inverts whatever drives the output line.
// - External input change accepted only after persisting the filter time.
`include "tot_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tot_trigger_timer #(
  parameter int unsigned CNT_W = `TOT_CNT_W,
  parameter int unsigned FILT_W = `TOT_FILT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`TOT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [`TOT_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`TOT_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`TOT_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic exposure_window_signal,
  input wire logic readout_window_signal,
  input wire logic external_trigger_input,
  output logic line_out,
  output logic pulse_gen_active
);
  import tot_pkg::*;

  localparam logic [`TOT_DIV_W-1:0] TICK_LAST = `TOT_DIV_W'(`TOT_TICK_CYC - 1);

  // Configuration
  tot_ctrl_s ctrl_q;
  logic [CNT_W-1:0] pulse_length_us_q;
  logic [CNT_W-1:0] start_wait_us_q;
  logic [FILT_W-1:0] input_filter_time_q;
  logic restart_command_q;

  // AXI slave state
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [`TOT_ADDR_W-1:0] awaddr_q;
  logic [`TOT_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [`TOT_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;

  // Timing state
  logic [`TOT_DIV_W-1:0] div_q;
  logic tick_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_filt_q;
  logic [FILT_W-1:0] filt_cnt_q;
  logic src_q;
  tot_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic line_out_q;
  logic active_q;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_ok;
  logic [`TOT_DATA_W-1:0] rd_word;
  logic rd_ok;
  logic src;
  logic enabled;
  logic level_mode;
  logic asserted;
  logic trig_edge;
  logic start;
  logic drive;
  logic [CNT_W-1:0] cnt_inc;
  logic [`TOT_DATA_W-1:0] ctrl_word;

  assign aw_hs = s_axi_awvalid && awready_q;
  assign w_hs = s_axi_wvalid && wready_q;
  assign ar_hs = s_axi_arvalid && arready_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign cnt_inc = cnt_q + CNT_W'(1);
  assign ctrl_word = merge(`TOT_DATA_W'(ctrl_q), wdata_q, wstrb_q);

  function automatic logic [`TOT_DATA_W-1:0] merge(
    input logic [`TOT_DATA_W-1:0] old_word,
    input logic [`TOT_DATA_W-1:0] new_word,
    input logic [3:0] strb
  );
    logic [`TOT_DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write address channel; one write in flight at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      awready_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      awready_q <= !aw_have_q && !aw_hs && !bvalid_q;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      wready_q <= 1'b0;
    end else begin
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      wready_q <= !w_have_q && !w_hs && !bvalid_q;
    end
  end

  always_comb begin
    case (awaddr_q)
      `TOT_OFS_CTRL, `TOT_OFS_PULSE, `TOT_OFS_WAIT, `TOT_OFS_FILT, `TOT_OFS_CMD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `TOT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? `TOT_RESP_OKAY : `TOT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= tot_ctrl_s'(`TOT_RST_CTRL);
      pulse_length_us_q <= CNT_W'(`TOT_RST_PULSE);
      start_wait_us_q <= CNT_W'(`TOT_RST_WAIT);
      input_filter_time_q <= FILT_W'(`TOT_RST_FILT);
    end else if (wr_fire) begin
      case (awaddr_q)
        `TOT_OFS_CTRL: begin
          ctrl_q <= tot_ctrl_s'(ctrl_word[`TOT_CTRL_W-1:0]);
        end
        `TOT_OFS_PULSE: begin
          pulse_length_us_q <= CNT_W'(merge(`TOT_DATA_W'(pulse_length_us_q), wdata_q, wstrb_q));
        end
        `TOT_OFS_WAIT: begin
          start_wait_us_q <= CNT_W'(merge(`TOT_DATA_W'(start_wait_us_q), wdata_q, wstrb_q));
        end
        `TOT_OFS_FILT: begin
          input_filter_time_q <= FILT_W'(merge(`TOT_DATA_W'(input_filter_time_q), wdata_q, wstrb_q));
        end
        default: begin
        end
      endcase
    end
  end

  // Restart is a one-cycle strobe; the register itself reads as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_command_q <= 1'b0;
    end else begin
      restart_command_q <= wr_fire && (awaddr_q == `TOT_OFS_CMD) && wstrb_q[0]
        && wdata_q[`TOT_CMD_RESTART_BIT];
    end
  end

  // Read path
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TOT_OFS_CTRL: rd_word = `TOT_DATA_W'(ctrl_q);
      `TOT_OFS_PULSE: rd_word = `TOT_DATA_W'(pulse_length_us_q);
      `TOT_OFS_WAIT: rd_word = `TOT_DATA_W'(start_wait_us_q);
      `TOT_OFS_FILT: rd_word = `TOT_DATA_W'(input_filter_time_q);
      `TOT_OFS_CMD: rd_word = '0;
      `TOT_OFS_STAT: begin
        rd_word[`TOT_STAT_STATE_LSB +: 2] = 2'(state_q);
        rd_word[`TOT_STAT_ACTIVE_BIT] = active_q;
        rd_word[`TOT_STAT_EXT_BIT] = ext_filt_q;
        rd_word[`TOT_STAT_LINE_BIT] = line_out_q;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `TOT_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !ar_hs;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? `TOT_RESP_OKAY : `TOT_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Microsecond base; re-phased at each timer start so delays are whole us
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (start) begin
      // Start cycle counts as the first, else the wait, or the pulse when there is no wait, runs one cycle long
      div_q <= `TOT_DIV_W'(1);
      tick_q <= 1'b0;
    end else if (div_q == TICK_LAST) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + `TOT_DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // External pin synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_trigger_input;
      ext_sync_q <= ext_meta_q;
    end
  end

  // Glitch filter: the new level must hold for the whole filter time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_filt_q <= 1'b0;
      filt_cnt_q <= '0;
    end else if (ext_sync_q == ext_filt_q) begin
      filt_cnt_q <= '0;
    end else if ((filt_cnt_q > input_filter_time_q) || (input_filter_time_q == '0)) begin
      // One extra tick boundary so a glitch straddling a tick cannot pass
      ext_filt_q <= ext_sync_q;
      filt_cnt_q <= '0;
    end else if (tick_q) begin
      filt_cnt_q <= filt_cnt_q + FILT_W'(1);
    end
  end

  // Trigger source selection
  always_comb begin
    case (ctrl_q.trigger_origin_select)
      TOT_ORIG_EXPOSURE: src = exposure_window_signal;
      TOT_ORIG_READOUT: src = readout_window_signal;
      TOT_ORIG_EXTERNAL: src = ext_filt_q;
      default: src = 1'b0;
    endcase
  end

  assign enabled = ctrl_q.trigger_origin_select != TOT_ORIG_OFF;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src;
    end
  end

  always_comb begin
    level_mode = 1'b0;
    asserted = 1'b0;
    trig_edge = 1'b0;
    case (ctrl_q.trigger_condition_select)
      TOT_ON_LOW_TO_HIGH: trig_edge = src && !src_q;
      TOT_ON_HIGH_TO_LOW: trig_edge = !src && src_q;
      TOT_WHILE_ASSERTED_HIGH: begin
        level_mode = 1'b1;
        asserted = src;
      end
      TOT_WHILE_ASSERTED_LOW: begin
        level_mode = 1'b1;
        asserted = !src;
      end
      default: trig_edge = 1'b0;
    endcase
  end

  // Only an idle timer can start, so edges during wait or pulse are dropped
  assign start = enabled && (state_q == TOT_IDLE) && (level_mode ? asserted : trig_edge);

  // Wait-then-pulse sequencer
  always_ff @(posedge clk) begin
    if (sys_rst || restart_command_q || !enabled) begin
      state_q <= TOT_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        TOT_IDLE: begin
          if (start) begin
            cnt_q <= '0;
            state_q <= (start_wait_us_q == '0) ? TOT_PULSE : TOT_WAIT;
          end
        end
        TOT_WAIT: begin
          if (level_mode && !asserted) begin
            state_q <= TOT_IDLE;
          end else if (tick_q) begin
            if (cnt_inc >= start_wait_us_q) begin
              cnt_q <= '0;
              state_q <= TOT_PULSE;
            end else begin
              cnt_q <= cnt_inc;
            end
          end
        end
        TOT_PULSE: begin
          if (level_mode) begin
            if (!asserted) begin
              state_q <= TOT_IDLE;
            end
          end else if (tick_q) begin
            if (cnt_inc >= pulse_length_us_q) begin
              state_q <= TOT_IDLE;
            end else begin
              cnt_q <= cnt_inc;
            end
          end
        end
        default: begin
          state_q <= TOT_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Line driver
  always_comb begin
    case (ctrl_q.line_source)
      TOT_LINE_EXPOSURE: drive = exposure_window_signal;
      TOT_LINE_READOUT: drive = readout_window_signal;
      TOT_LINE_USER: drive = ctrl_q.user_value;
      TOT_LINE_PULSE_GEN: drive = active_q;
      default: drive = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_q <= 1'b0;
      line_out_q <= 1'b0;
    end else begin
      active_q <= (state_q == TOT_PULSE) && enabled && !restart_command_q;
      line_out_q <= drive ^ ctrl_q.output_polarity_flip;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign line_out = line_out_q;
  assign pulse_gen_active = active_q;

endmodule // tot_trigger_timer

`default_nettype wire

// file: sim/tot_timer_props.sv
`include "tot_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tot_timer_props
  import tot_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`TOT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [`TOT_DATA_W-1:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exposure_window_signal,
  input wire logic line_out,
  input wire logic pulse_gen_active
);
  tot_ctrl_s ctrl_q;
  logic [2:0] age_q;
  logic ctrl_wr;
  logic settled;
  // Shadow assumes address and data taken at one edge, as the bench offers them
  assign ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `TOT_OFS_CTRL;
  assign settled = age_q == 3'h7;
  always_ff @(posedge clk) begin
    if (sys_rst) ctrl_q <= '0;
    else if (ctrl_wr) ctrl_q <= tot_ctrl_s'(s_axi_wdata[`TOT_CTRL_W-1:0]);
  end
  always_ff @(posedge clk) begin
    if (sys_rst || ctrl_wr) age_q <= 3'h0;
    else if (!settled) age_q <= age_q + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (disable iff (1'h0) sys_rst |=> !pulse_gen_active && !line_out && !s_axi_bvalid)
    else $error("outputs not quiet after reset");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
    else $error("request accepted while busy");
  a_line_follow: assert property (settled && ctrl_q.line_source == TOT_LINE_PULSE_GEN |->
    line_out == ($past(pulse_gen_active) ^ ctrl_q.output_polarity_flip)) else $error("line does not follow timer");
  a_origin_off: assert property (settled && ctrl_q.trigger_origin_select == TOT_ORIG_OFF |-> !pulse_gen_active)
    else $error("timer active with origin off");
  a_level_gate: assert property (settled && ctrl_q.trigger_origin_select == TOT_ORIG_EXPOSURE &&
    ctrl_q.trigger_condition_select == TOT_WHILE_ASSERTED_HIGH && pulse_gen_active |->
    $past(exposure_window_signal, 2) || $past(exposure_window_signal, 3)) else $error("level output without source");
  c_pulse_end: cover property ($fell(pulse_gen_active));
  c_flip_pulse: cover property (ctrl_q.output_polarity_flip && pulse_gen_active);
  c_level: cover property (settled && ctrl_q.trigger_condition_select == TOT_WHILE_ASSERTED_HIGH && pulse_gen_active);
endmodule // tot_timer_props

bind tot_trigger_timer tot_timer_props i_props (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .exposure_window_signal, .line_out, .pulse_gen_active);
`default_nettype wire

// file: sim/tot_strobe_model.sv
`timescale 1ns/10ps
`default_nettype none
module tot_strobe_model (
  input wire logic clk,
  input wire logic line_level,
  input wire logic active_low,
  output logic lit,
  output int unsigned pulse_cnt,
  output int unsigned last_width
);
  int unsigned width_q;
  assign lit = line_level ^ active_low;
  initial begin
    pulse_cnt = 0;
    last_width = 0;
    width_q = 0;
  end
  // Equipment counts a strobe only once it has ended
  always @(posedge clk) begin
    if (lit) begin
      width_q <= width_q + 1;
    end else if (width_q != 0) begin
      last_width <= width_q;
      pulse_cnt <= pulse_cnt + 1;
      width_q <= 0;
    end
  end
endmodule // tot_strobe_model
`default_nettype wire

// file: sim/tot_trigger_timer_tb.sv
`include "tot_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tot_trigger_timer_tb;
  import tot_pkg::*;
  localparam int TK = `TOT_TICK_CYC;
  typedef struct {
    tot_origin_e org;
    tot_cond_e cnd;
    logic flip;
    int wt;
    int pl;
    int hi;
    int d_lo;
    int d_hi;
    int w_lo;
    int w_hi;
  } tot_row_s;
  tot_row_s rows[4] = '{
    '{TOT_ORIG_EXPOSURE, TOT_ON_LOW_TO_HIGH, 1'h0, 0, 1, 50, 1, 8, TK, TK},
    '{TOT_ORIG_EXTERNAL, TOT_ON_HIGH_TO_LOW, 1'h1, 1, 2, 800, TK + 1, 3 * TK + 10, 2 * TK, 2 * TK},
    '{TOT_ORIG_EXPOSURE, TOT_WHILE_ASSERTED_HIGH, 1'h0, 0, 5, 300, 1, 8, 296, 303},
    '{TOT_ORIG_READOUT, TOT_WHILE_ASSERTED_LOW, 1'h0, 1, 1, 500, TK + 1, TK + 8, 500 - TK - 6, 500 - TK + 3}
  };
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [3:0] src = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_out, pulse_gen_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  wire logic exposure_window_signal = src[1];
  wire logic readout_window_signal = src[2];
  wire logic external_trigger_input = src[3];
  logic active_low = 1'h0;
  logic lit;
  int unsigned pulse_cnt, last_width;
  int failures = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  tot_trigger_timer i_dut (.*);
  tot_strobe_model i_strobe (.clk(clk), .line_level(line_out), .active_low(active_low), .lit(lit),
    .pulse_cnt(pulse_cnt), .last_width(last_width));

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 2000) begin
      failures++;
      $display("[ERR] handshake exp answer got timeout");
      summarize();
    end
  endtask

  task automatic check_eq(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic check_rng(string nm, int lo, int hi, int got);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int n = 0;
    logic aw = 1'h0;
    logic w = 1'h0;
    @(posedge clk);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk);
      guard(n);
      if (s_axi_awready && !aw) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && !w) s_axi_wvalid <= 1'h0;
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
    end
    do begin
      if (!s_axi_bvalid) @(posedge clk);
      guard(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check_eq("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int n = 0;
    @(posedge clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      guard(n);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge clk);
      guard(n);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check_eq("rdata", ed, s_axi_rdata);
    check_eq("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic cfg(tot_origin_e o, tot_cond_e c, tot_line_src_e ls, logic f, logic u);
    tot_ctrl_s s;
    s = '{user_value: u, output_polarity_flip: f, line_source: ls, trigger_condition_select: c,
      trigger_origin_select: o};
    wr(`TOT_OFS_CTRL, {23'h0, s}, `TOT_RESP_OKAY);
    active_low <= f;
  endtask

  // Origin off first so moving the idle levels cannot fire the old setup
  task automatic setup(tot_row_s r, logic idle);
    cfg(TOT_ORIG_OFF, r.cnd, TOT_LINE_PULSE_GEN, r.flip, 1'h0);
    src <= {4{idle}};
    wr(`TOT_OFS_PULSE, 32'(r.pl), `TOT_RESP_OKAY);
    wr(`TOT_OFS_WAIT, 32'(r.wt), `TOT_RESP_OKAY);
    repeat (600) @(posedge clk);
    cfg(r.org, r.cnd, TOT_LINE_PULSE_GEN, r.flip, 1'h0);
    repeat (20) @(posedge clk);
  endtask

  // Source active for hi cycles, again from ag; stops when a strobe ends or at lim
  task automatic fire(int pin, logic idle, int hi, int ag, int lim, output int d, output int cnt);
    int n0 = int'(pulse_cnt);
    d = -1;
    for (int c = 0; c < lim && int'(pulse_cnt) == n0; c++) begin
      src[pin] <= ((c < hi) || (c >= ag && c < ag + hi)) ? ~idle : idle;
      @(posedge clk);
      if (lit && d < 0) d = c;
    end
    src[pin] <= idle;
    cnt = int'(pulse_cnt) - n0;
  endtask

  initial begin
    tot_row_s r;
    logic idle;
    int d, cnt;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    check_eq("line_out", 32'h0, {31'h0, line_out});
    check_eq("pulse_gen_active", 32'h0, {31'h0, pulse_gen_active});
    rd(`TOT_OFS_PULSE, 32'h0000_0001, `TOT_RESP_OKAY);
    rd(`TOT_OFS_WAIT, 32'h0000_0000, `TOT_RESP_OKAY);
    rd(8'h18, 32'h0000_0000, `TOT_RESP_SLVERR);
    wr(8'h18, 32'h0000_00ff, `TOT_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      idle = r.cnd inside {TOT_ON_HIGH_TO_LOW, TOT_WHILE_ASSERTED_LOW};
      setup(r, idle);
      fire(int'(r.org), idle, r.hi, 99999, 5000, d, cnt);
      check_eq("pulses", 32'h1, 32'(cnt));
      check_rng("delay", r.d_lo, r.d_hi, d);
      check_rng("width", r.w_lo, r.w_hi, int'(last_width));
    end
    r = rows[0];
    r.org = TOT_ORIG_OFF;
    setup(r, 1'h0);
    fire(1, 1'h0, 50, 99999, 800, d, cnt);
    check_eq("off pulses", 32'h0, 32'(cnt));
    r = rows[0];
    r.pl = 3;
    setup(r, 1'h0);
    fire(1, 1'h0, 50, 100, 5000, d, cnt);
    check_eq("busy pulses", 32'h1, 32'(cnt));
    check_eq("busy width", 32'(3 * TK), last_width);
    fire(1, 1'h0, 50, 99999, 150, d, cnt);
    wr(`TOT_OFS_CMD, 32'h0000_0001, `TOT_RESP_OKAY);
    repeat (20) @(posedge clk);
    check_eq("restart active", 32'h0, {31'h0, pulse_gen_active});
    check_rng("cut width", 140, 200, int'(last_width));
    fire(1, 1'h0, 50, 99999, 5000, d, cnt);
    check_eq("resume width", 32'(3 * TK), last_width);
    r = rows[2];
    r.wt = 2;
    setup(r, 1'h0);
    fire(1, 1'h0, 100, 99999, 800, d, cnt);
    check_eq("early drop", 32'h0, 32'(cnt));
    r = rows[0];
    r.org = TOT_ORIG_EXTERNAL;
    setup(r, 1'h0);
    fire(3, 1'h0, 50, 99999, 1000, d, cnt);
    check_eq("glitch", 32'h0, 32'(cnt));
    cfg(TOT_ORIG_OFF, TOT_ON_LOW_TO_HIGH, TOT_LINE_USER, 1'h0, 1'h1);
    repeat (5) @(posedge clk);
    check_eq("user line", {31'h0, line_out}, 32'h1);
    cfg(TOT_ORIG_OFF, TOT_ON_LOW_TO_HIGH, TOT_LINE_USER, 1'h1, 1'h1);
    repeat (5) @(posedge clk);
    check_eq("flipped line", {31'h0, line_out}, 32'h0);
    summarize();
  end
endmodule // tot_trigger_timer_tb
`default_nettype wire
